// *** src/pwm_ctl_defines.svh ***
`ifndef PWM_CTL_DEFINES_SVH
`define PWM_CTL_DEFINES_SVH

// Register offsets on the byte-wide register port.
`define ADDR_INTERLEAVE 8'h00
`define ADDR_FREQ 8'h01
`define ADDR_DUTY_LIMIT 8'h02
`define ADDR_CTRL 8'h03
`define ADDR_SETPOINT 8'h04
`define ADDR_WINDOW 8'h05
`define ADDR_LOAD_REG 8'h06
`define ADDR_STATUS 8'h07
`define ADDR_NUM_BASE 8'h08
`define ADDR_DEN_BASE 8'h10
`define ADDR_VMON 8'h18
`define ADDR_IMON 8'h19
`define ADDR_TEMPERATURE_MONITOR_REG 8'h1A

// Field positions.
`define DCL_SAT_BIT 7
`define CTRL_ON_BIT 0
`define CTRL_RETRIEVE_BIT 1

// Reset values.
`define INTERLEAVE_RST 5'h00
`define DUTY_LIMIT_RST 8'h60
`define SETPOINT_RST 8'h80
`define WINDOW_RST 8'h10
`define LOAD_REG_RST 8'h00
`define NUM_HI_RST 8'h00
`define NUM_LO_RST 8'h10
`define DEN1_RST 8'h40
`define DEN_RST 8'h00

// Timing.
`define CLK_HZ 50000000
`define FSW_500K_HZ 500000
`define FSW_750K_HZ 750000
`define FSW_1M_HZ 1000000
`define PHASE_SHIFT 5
`define DUTY_SHIFT 7
`define MON_RATE_HZ 700
`define MON_CHANNELS 3
`define MON_SAMPLE_CYC (`CLK_HZ / (`MON_RATE_HZ * `MON_CHANNELS))
`define TEMP_REF 8'h40
`define TEMP_COEF_SHIFT 8

`endif

// *** src/pwm_ctl_pkg.sv ***
package pwm_ctl_pkg;

  typedef enum logic [1:0] {
    freq_500k = 2'b00,
    freq_750k = 2'b01,
    freq_1m = 2'b10
  } freq_type;

  typedef enum logic [1:0] {
    st_off = 2'b00,
    st_wait = 2'b01,
    st_run = 2'b10
  } pwm_state_type;

  typedef enum logic [1:0] {
    mon_volt = 2'b00,
    mon_curr = 2'b01,
    mon_temp = 2'b10
  } mon_ch_type;

endpackage

// *** src/comp_filter.sv ***
`timescale 1ns/1ps
module comp_filter #(
  parameter int ERR_W = 11,
  parameter int OUT_W = 16,
  parameter int C_FRAC = 8,
  parameter int B_FRAC = 6
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic step_i,
  input wire logic signed [ERR_W-1:0] err_i,
  input wire logic signed [15:0] c0_i,
  input wire logic signed [15:0] c1_i,
  input wire logic signed [15:0] c2_i,
  input wire logic signed [15:0] c3_i,
  input wire logic signed [7:0] b1_i,
  input wire logic signed [7:0] b2_i,
  input wire logic signed [7:0] b3_i,
  output logic signed [OUT_W-1:0] u_o
);
  localparam logic signed [31:0] MAX_U = 32'(2 ** (OUT_W - 1) - 1);
  localparam logic signed [31:0] MIN_U = -32'(2 ** (OUT_W - 1));

  logic signed [ERR_W-1:0] e_tap [4];
  logic signed [OUT_W-1:0] u_tap [4];
  logic signed [15:0] c [4];
  logic signed [7:0] b [4];
  logic signed [31:0] acc_c;
  logic signed [31:0] acc_b;
  logic signed [31:0] sum;
  logic signed [OUT_W-1:0] next_u;

  assign c = '{c0_i, c1_i, c2_i, c3_i};
  assign b = '{8'sh00, b1_i, b2_i, b3_i};
  assign e_tap[0] = err_i;
  assign u_tap[0] = u_o;

  // Four zeros-side taps and three poles-side taps; b1 = 1.0 gives the
  // integrator pole.
  always_comb begin
    acc_c = '0;
    acc_b = '0;
    for (int i = 0; i < 4; i++) begin
      acc_c = acc_c + 32'(c[i] * e_tap[i]);
      acc_b = acc_b + 32'(b[i] * u_tap[i]);
    end
    sum = (acc_c >>> C_FRAC) + (acc_b >>> B_FRAC);
    if (sum > MAX_U) begin
      next_u = MAX_U[OUT_W-1:0];
    end else if (sum < MIN_U) begin
      next_u = MIN_U[OUT_W-1:0];
    end else begin
      next_u = sum[OUT_W-1:0];
    end
  end

  genvar g;
  generate
    for (g = 1; g < 4; g++) begin : g_tap
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          e_tap[g] <= '0;
          u_tap[g] <= '0;
        end else if (step_i) begin
          e_tap[g] <= e_tap[g-1];
          u_tap[g] <= (g == 1) ? next_u : u_tap[g-1];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      u_o <= '0;
    end else if (step_i) begin
      u_o <= next_u;
    end
  end
endmodule

// *** src/mon_adc.sv ***
`timescale 1ns/1ps
`include "pwm_ctl_defines.svh"
module mon_adc import pwm_ctl_pkg::*; #(
  parameter int SAMPLE_CYC = `MON_SAMPLE_CYC
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] adc_data_i,
  input wire logic adc_valid_i,
  output logic adc_start_o,
  output logic [1:0] adc_sel_o,
  output logic [7:0] vmon_o,
  output logic [7:0] imon_o,
  output logic [7:0] temperature_monitor_reg_o,
  output logic new_o,
  output logic [1:0] new_ch_o
);
  localparam int TW = $clog2(SAMPLE_CYC + 1);

  mon_ch_type ch, next_ch;
  logic [TW-1:0] tick, next_tick;
  logic next_start;
  logic [7:0] next_vmon, next_imon, next_temperature_monitor_reg;
  logic next_new;
  logic [1:0] next_new_ch;
  logic signed [8:0] temp_diff;
  logic signed [17:0] drift;
  logic signed [10:0] corr;

  // Copper resistance rises with temperature, so the raw sense reading is
  // scaled back toward its value at the reference temperature.
  always_comb begin
    temp_diff = $signed({1'b0, temperature_monitor_reg_o}) - $signed({1'b0, `TEMP_REF});
    drift = $signed({1'b0, adc_data_i}) * temp_diff;
    corr = $signed({3'b000, adc_data_i})
      - 11'(drift >>> `TEMP_COEF_SHIFT);
  end

  // One channel is started every SAMPLE_CYC cycles, so each of the three
  // quantities is converted at the minimum rate or faster.
  always_comb begin
    next_tick = tick + TW'(1);
    next_start = 1'b0;
    if (tick == TW'(SAMPLE_CYC - 1)) begin
      next_tick = '0;
      next_start = 1'b1;
    end
    next_ch = ch;
    next_vmon = vmon_o;
    next_imon = imon_o;
    next_temperature_monitor_reg = temperature_monitor_reg_o;
    next_new = 1'b0;
    next_new_ch = new_ch_o;
    if (adc_valid_i) begin
      next_new = 1'b1;
      next_new_ch = ch;
      unique case (ch)
        mon_volt: begin
          next_vmon = adc_data_i;
          next_ch = mon_curr;
        end
        mon_curr: begin
          if (corr < 0) begin
            next_imon = 8'h00;
          end else if (corr > 11'sd255) begin
            next_imon = 8'hFF;
          end else begin
            next_imon = corr[7:0];
          end
          next_ch = mon_temp;
        end
        mon_temp: begin
          next_temperature_monitor_reg = adc_data_i;
          next_ch = mon_volt;
        end
        default: begin
          next_ch = mon_volt;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick <= '0;
      ch <= mon_volt;
      adc_start_o <= 1'b0;
      vmon_o <= 8'h00;
      imon_o <= 8'h00;
      temperature_monitor_reg_o <= 8'h00;
      new_o <= 1'b0;
      new_ch_o <= 2'h0;
    end else begin
      tick <= next_tick;
      ch <= next_ch;
      adc_start_o <= next_start;
      vmon_o <= next_vmon;
      imon_o <= next_imon;
      temperature_monitor_reg_o <= next_temperature_monitor_reg;
      new_o <= next_new;
      new_ch_o <= next_new_ch;
    end
  end

  assign adc_sel_o = ch;
endmodule

// *** src/digital_pwm_interleave_control.sv ***
`timescale 1ns/1ps
`include "pwm_ctl_defines.svh"
module digital_pwm_interleave_control import pwm_ctl_pkg::*; #(
  parameter int MON_SAMPLE_CYC = `MON_SAMPLE_CYC
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic sync_line_i,
  output logic pwm_o,
  input wire logic [7:0] share_level_i,
  output logic [7:0] share_level_o,
  input wire logic [7:0] adc_data_i,
  input wire logic adc_valid_i,
  output logic adc_start_o,
  output logic [1:0] adc_sel_o,
  output logic mon_valid_o,
  output logic [1:0] mon_ch_o,
  output logic [7:0] mon_data_o
);
  localparam logic [7:0] PERIOD_500K = 8'(`CLK_HZ / `FSW_500K_HZ);
  localparam logic [7:0] PERIOD_750K = 8'(`CLK_HZ / `FSW_750K_HZ);
  localparam logic [7:0] PERIOD_1M = 8'(`CLK_HZ / `FSW_1M_HZ);

  // Register file state.
  logic [4:0] interleave, next_interleave;
  freq_type freq, next_freq;
  logic [7:0] duty_limit_reg, next_duty_limit_reg;
  logic out_on, next_out_on;
  logic retrieve, next_retrieve;
  logic [7:0] setpoint, next_setpoint;
  logic [7:0] window, next_window;
  logic [7:0] load_reg, next_load_reg;
  logic [7:0] num_hi [4];
  logic [7:0] next_num_hi [4];
  logic [7:0] num_lo [4];
  logic [7:0] next_num_lo [4];
  logic [7:0] den [3];
  logic [7:0] next_den [3];
  logic [7:0] next_rdata;

  // PWM timing state.
  pwm_state_type state, next_state;
  logic [7:0] cnt, next_cnt;
  logic [7:0] phase_cnt, next_phase_cnt;
  logic armed, next_armed;
  logic [6:0] duty_cur, next_duty_cur;
  logic next_pwm;
  logic sync_prev;
  logic sync_edge;
  logic hit;
  logic period_start;
  logic [7:0] period;
  logic [7:0] phase_cyc;
  logic [7:0] on_cyc;

  // Control path.
  logic [7:0] vmon, imon, temperature_monitor_reg;
  logic mon_new;
  logic [1:0] mon_new_ch;
  logic signed [9:0] err_v;
  logic signed [9:0] err_share;
  logic signed [10:0] err_total;
  logic signed [15:0] u;
  logic [6:0] limit;
  logic sat_en, sat_hi, sat_lo;
  logic [6:0] duty_lin, duty_target;
  logic next_mon_valid;
  logic [1:0] next_mon_ch;
  logic [7:0] next_mon_data;

  // Register writes. Interleave and frequency are locked while the output
  // runs, since moving the phase mid-run would tear a switching period.
  always_comb begin
    next_interleave = interleave;
    next_freq = freq;
    next_duty_limit_reg = duty_limit_reg;
    next_out_on = out_on;
    next_retrieve = retrieve;
    next_setpoint = setpoint;
    next_window = window;
    next_load_reg = load_reg;
    next_num_hi = num_hi;
    next_num_lo = num_lo;
    next_den = den;
    if (wr_i) begin
      case (addr_i)
        `ADDR_INTERLEAVE: begin
          if (!out_on) begin
            next_interleave = wdata_i[4:0];
          end
        end
        `ADDR_FREQ: begin
          if (!out_on && wdata_i[1:0] != 2'h3) begin
            next_freq = freq_type'(wdata_i[1:0]);
          end
        end
        `ADDR_DUTY_LIMIT: next_duty_limit_reg = wdata_i;
        `ADDR_CTRL: begin
          next_out_on = wdata_i[`CTRL_ON_BIT];
          next_retrieve = wdata_i[`CTRL_RETRIEVE_BIT];
        end
        `ADDR_SETPOINT: next_setpoint = wdata_i;
        `ADDR_WINDOW: next_window = wdata_i;
        `ADDR_LOAD_REG: next_load_reg = wdata_i;
        default: begin
        end
      endcase
      if (addr_i[7:3] == `ADDR_NUM_BASE >> 3) begin
        if (addr_i[0]) begin
          next_num_lo[addr_i[2:1]] = wdata_i;
        end else begin
          next_num_hi[addr_i[2:1]] = wdata_i;
        end
      end
      if (addr_i >= `ADDR_DEN_BASE && addr_i < `ADDR_DEN_BASE + 8'h03) begin
        next_den[2'(addr_i - `ADDR_DEN_BASE)] = wdata_i;
      end
    end
  end

  // Read data stand for the one cycle after the strobe; unmapped reads
  // return zero.
  always_comb begin
    next_rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `ADDR_INTERLEAVE: next_rdata = {3'h0, interleave};
        `ADDR_FREQ: next_rdata = {6'h00, freq};
        `ADDR_DUTY_LIMIT: next_rdata = duty_limit_reg;
        `ADDR_CTRL: next_rdata = {6'h00, retrieve, out_on};
        `ADDR_SETPOINT: next_rdata = setpoint;
        `ADDR_WINDOW: next_rdata = window;
        `ADDR_LOAD_REG: next_rdata = load_reg;
        `ADDR_STATUS: next_rdata = {2'h0, armed, sat_hi, sat_lo, 1'b0, state};
        `ADDR_VMON: next_rdata = vmon;
        `ADDR_IMON: next_rdata = imon;
        `ADDR_TEMPERATURE_MONITOR_REG: next_rdata = temperature_monitor_reg;
        default: begin
          if (addr_i[7:3] == `ADDR_NUM_BASE >> 3) begin
            next_rdata = addr_i[0] ? num_lo[addr_i[2:1]]
                                   : num_hi[addr_i[2:1]];
          end else if (addr_i >= `ADDR_DEN_BASE
                       && addr_i < `ADDR_DEN_BASE + 8'h03) begin
            next_rdata = den[2'(addr_i - `ADDR_DEN_BASE)];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      interleave <= `INTERLEAVE_RST;
      freq <= freq_500k;
      duty_limit_reg <= `DUTY_LIMIT_RST;
      out_on <= 1'b0;
      retrieve <= 1'b0;
      setpoint <= `SETPOINT_RST;
      window <= `WINDOW_RST;
      load_reg <= `LOAD_REG_RST;
      num_hi <= '{default: `NUM_HI_RST};
      num_lo <= '{default: `NUM_LO_RST};
      den <= '{`DEN1_RST, `DEN_RST, `DEN_RST};
      rdata_o <= 8'h00;
    end else begin
      interleave <= next_interleave;
      freq <= next_freq;
      duty_limit_reg <= next_duty_limit_reg;
      out_on <= next_out_on;
      retrieve <= next_retrieve;
      setpoint <= next_setpoint;
      window <= next_window;
      load_reg <= next_load_reg;
      num_hi <= next_num_hi;
      num_lo <= next_num_lo;
      den <= next_den;
      rdata_o <= next_rdata;
    end
  end

  // Divider ratio of the switching period to the system clock.
  always_comb begin
    unique case (freq)
      freq_500k: period = PERIOD_500K;
      freq_750k: period = PERIOD_750K;
      freq_1m: period = PERIOD_1M;
      default: period = PERIOD_500K;
    endcase
    // Each code step is 1/32 of a period, i.e. 11.25 degrees.
    phase_cyc = 8'((16'(interleave) * 16'(period)) >> `PHASE_SHIFT);
  end

  assign sync_edge = sync_line_i && !sync_prev;
  // A zero phase restarts the period on the sync edge itself.
  assign hit = (sync_edge && phase_cyc == 8'h00)
               || (armed && phase_cnt == 8'h00);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_duty_cur = duty_cur;
    next_armed = armed;
    next_phase_cnt = phase_cnt;
    period_start = 1'b0;
    next_pwm = 1'b0;
    if (sync_edge && phase_cyc != 8'h00) begin
      next_armed = 1'b1;
      next_phase_cnt = phase_cyc - 8'h01;
    end else if (armed) begin
      if (phase_cnt == 8'h00) begin
        next_armed = 1'b0;
      end else begin
        next_phase_cnt = phase_cnt - 8'h01;
      end
    end
    unique case (state)
      st_off: begin
        next_cnt = 8'h00;
        next_armed = 1'b0;
        if (out_on) begin
          next_state = st_wait;
        end
      end
      st_wait: begin
        if (!out_on) begin
          next_state = st_off;
        end else if (hit) begin
          next_state = st_run;
          next_cnt = 8'h00;
          period_start = 1'b1;
        end
      end
      st_run: begin
        if (!out_on) begin
          next_state = st_off;
        end else if (hit || cnt >= period - 8'h01) begin
          // Between sync edges the divider free-runs at its own period.
          next_cnt = 8'h00;
          period_start = 1'b1;
        end else begin
          next_cnt = cnt + 8'h01;
        end
      end
    endcase
    if (period_start) begin
      next_duty_cur = duty_target;
    end
    on_cyc = 8'((16'(next_duty_cur) * 16'(period)) >> `DUTY_SHIFT);
    if (next_state == st_run) begin
      next_pwm = next_cnt < on_cyc;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= st_off;
      cnt <= 8'h00;
      phase_cnt <= 8'h00;
      armed <= 1'b0;
      duty_cur <= 7'h00;
      sync_prev <= 1'b0;
      pwm_o <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      phase_cnt <= next_phase_cnt;
      armed <= next_armed;
      duty_cur <= next_duty_cur;
      sync_prev <= sync_line_i;
      pwm_o <= next_pwm;
    end
  end

  // Error terms. The share term pulls this unit's current toward the common
  // level; load regulation attenuates it to lower the share loop gain.
  always_comb begin
    err_v = $signed({2'b00, setpoint}) - $signed({2'b00, vmon});
    err_share = ($signed({2'b00, share_level_i})
                 - $signed({2'b00, imon})) >>> load_reg[2:0];
    err_total = 11'(err_v) + 11'(err_share);
  end

  comp_filter #(
    .ERR_W(11),
    .OUT_W(16)
  ) u_filter (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .step_i(period_start),
    .err_i(err_total),
    .c0_i({num_hi[0], num_lo[0]}),
    .c1_i({num_hi[1], num_lo[1]}),
    .c2_i({num_hi[2], num_lo[2]}),
    .c3_i({num_hi[3], num_lo[3]}),
    .b1_i(den[0]),
    .b2_i(den[1]),
    .b3_i(den[2]),
    .u_o(u)
  );

  // Saturation feedforward bypasses the loop for large transients. High
  // limits with saturation on can overcompensate; the window must be sized
  // by software, as this logic cannot detect that.
  always_comb begin
    limit = duty_limit_reg[6:0];
    sat_en = duty_limit_reg[`DCL_SAT_BIT];
    sat_hi = sat_en && (err_v > $signed({2'b00, window}));
    sat_lo = sat_en && (err_v < -$signed({2'b00, window}));
    if (u < 0) begin
      duty_lin = 7'h00;
    end else if (u > $signed({9'h000, limit})) begin
      duty_lin = limit;
    end else begin
      duty_lin = u[6:0];
    end
    if (sat_hi) begin
      duty_target = limit;
    end else if (sat_lo) begin
      duty_target = 7'h00;
    end else begin
      duty_target = duty_lin;
    end
  end

  mon_adc #(
    .SAMPLE_CYC(MON_SAMPLE_CYC)
  ) u_mon (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .adc_data_i(adc_data_i),
    .adc_valid_i(adc_valid_i),
    .adc_start_o(adc_start_o),
    .adc_sel_o(adc_sel_o),
    .vmon_o(vmon),
    .imon_o(imon),
    .temperature_monitor_reg_o(temperature_monitor_reg),
    .new_o(mon_new),
    .new_ch_o(mon_new_ch)
  );

  // Each fresh result is offered to the manager's ring buffer only while
  // retrieval is selected.
  always_comb begin
    next_mon_valid = retrieve && mon_new;
    next_mon_ch = mon_ch_o;
    next_mon_data = mon_data_o;
    if (retrieve && mon_new) begin
      next_mon_ch = mon_new_ch;
      unique case (mon_new_ch)
        2'h0: next_mon_data = vmon;
        2'h1: next_mon_data = imon;
        2'h2: next_mon_data = temperature_monitor_reg;
        default: next_mon_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mon_valid_o <= 1'b0;
      mon_ch_o <= 2'h0;
      mon_data_o <= 8'h00;
      share_level_o <= 8'h00;
    end else begin
      mon_valid_o <= next_mon_valid;
      mon_ch_o <= next_mon_ch;
      mon_data_o <= next_mon_data;
      share_level_o <= imon;
    end
  end
endmodule

// *** test/pwm_ctl_props.sv ***
`timescale 1ns/1ps
module pwm_ctl_checker (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] adc_data_i,
  input wire logic adc_valid_i,
  input wire logic adc_start_o,
  input wire logic [1:0] adc_sel_o,
  input wire logic mon_valid_o,
  input wire logic [1:0] mon_ch_o,
  input wire logic [7:0] mon_data_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_rd_idle;
    !$past(rd_i) |-> rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data without a read");
  property p_start_pulse;
    adc_start_o |=> !adc_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("conversion start longer than one cycle");
  property p_sel_step;
    adc_valid_i |=> adc_sel_o == (($past(adc_sel_o) == 2'h2) ? 2'h0 :
      $past(adc_sel_o) + 2'h1);
  endproperty
  a_sel_step: assert property (p_sel_step)
    else $error("channel did not advance");
  property p_sel_hold;
    !adc_valid_i |=> $stable(adc_sel_o);
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("channel moved without a result");
  property p_mon_src;
    mon_valid_o |-> $past(adc_valid_i, 2);
  endproperty
  a_mon_src: assert property (p_mon_src)
    else $error("monitor word without a conversion");
  property p_mon_pulse;
    mon_valid_o |=> !mon_valid_o;
  endproperty
  a_mon_pulse: assert property (p_mon_pulse)
    else $error("monitor word strobe too long");
  property p_mon_data;
    (mon_valid_o && mon_ch_o != 2'h1) |-> mon_data_o == $past(adc_data_i, 2);
  endproperty
  a_mon_data: assert property (p_mon_data)
    else $error("monitor word not the latest result");
  property p_mon_ch;
    mon_valid_o |-> mon_ch_o == $past(adc_sel_o, 2);
  endproperty
  a_mon_ch: assert property (p_mon_ch)
    else $error("monitor word carries wrong channel");
endmodule

bind digital_pwm_interleave_control pwm_ctl_checker pwm_ctl_checker_inst (
  .clock_i(clock_i),
  .rst_n_i(rst_n_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .adc_data_i(adc_data_i),
  .adc_valid_i(adc_valid_i),
  .adc_start_o(adc_start_o),
  .adc_sel_o(adc_sel_o),
  .mon_valid_o(mon_valid_o),
  .mon_ch_o(mon_ch_o),
  .mon_data_o(mon_data_o)
);

// *** test/power_manager_model.sv ***
`timescale 1ns/1ps
module power_manager_model #(
  parameter int SYNC_CYC = 100
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic adc_start_i,
  input wire logic [1:0] adc_sel_i,
  output logic sync_line_o = 1'b0,
  output logic adc_valid_o = 1'b0,
  output logic [7:0] adc_data_o = 8'h00
);
  int sync_cnt = 0;
  int wait_cnt = 0;
  logic slow = 1'b0;
  // The master clock runs free, half high and half low.
  always @(posedge clock_i) begin
    sync_cnt <= (sync_cnt == SYNC_CYC - 1) ? 0 : sync_cnt + 1;
    sync_line_o <= (sync_cnt < SYNC_CYC / 2);
  end
  // Answers alternate fast and slow; data toggles when not valid.
  always @(posedge clock_i) begin
    adc_valid_o <= 1'b0;
    adc_data_o <= ~adc_data_o;
    if (adc_start_i) begin
      wait_cnt <= slow ? 4 : 1;
      slow <= !slow;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
      if (wait_cnt == 1) begin
        adc_valid_o <= 1'b1;
        adc_data_o <= (adc_sel_i == 2'h0) ? 8'h00 :
          ((adc_sel_i == 2'h1) ? 8'h80 : 8'h60);
      end
    end
  end
endmodule

// *** test/digital_pwm_interleave_control_tb_top.sv ***
`timescale 1ns/1ps
module digital_pwm_interleave_control_tb_top;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic sync_line_i;
  logic pwm_o;
  logic [7:0] adc_data_i;
  logic adc_valid_i;
  logic adc_start_o;
  logic [1:0] adc_sel_o;
  logic mon_valid_o;
  logic [1:0] mon_ch_o;
  logic [7:0] mon_data_o;
  logic [7:0] share_level_o;
  logic [7:0] rd_val;
  logic [7:0] rst_addr [8] = '{8'h02, 8'h04, 8'h05, 8'h08, 8'h09, 8'h10,
    8'h11, 8'h1F};
  logic [7:0] rst_val [8] = '{8'h60, 8'h80, 8'h10, 8'h00, 8'h10, 8'h40,
    8'h00, 8'h00};
  // Lag codes 10 and 11 stay unused.
  logic [7:0] codes [3] = '{8'h00, 8'h08, 8'h1F};
  int n_mismatch = 0;
  int checked = 0;
  int n_mon = 0;
  int dly;
  int wid;

  digital_pwm_interleave_control #(.MON_SAMPLE_CYC(20))
  digital_pwm_interleave_control_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sync_line_i(sync_line_i), .pwm_o(pwm_o), .share_level_i(8'h40),
    .share_level_o(share_level_o), .adc_data_i(adc_data_i),
    .adc_valid_i(adc_valid_i),
    .adc_start_o(adc_start_o), .adc_sel_o(adc_sel_o),
    .mon_valid_o(mon_valid_o), .mon_ch_o(mon_ch_o), .mon_data_o(mon_data_o)
  );
  power_manager_model power_manager_model_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .adc_start_i(adc_start_o),
    .adc_sel_i(adc_sel_o), .sync_line_o(sync_line_i),
    .adc_valid_o(adc_valid_i), .adc_data_o(adc_data_i)
  );

  initial begin
    forever #10 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    if (mon_valid_o === 1'b1) n_mon++;
  end

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stuck(input int i);
    if (i >= 600) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    rd_val = rdata_o;
  endtask
  task automatic wrchk(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    rd(a);
    chk(rd_val, d);
  endtask
  // Finds a sync rise, then counts cycles to the next rise of the output
  // and the length of its high phase.
  task automatic measure();
    logic prev;
    int i;
    prev = 1'b1;
    for (i = 0; i < 600; i++) begin
      @(posedge clock_i);
      #1;
      if (sync_line_i && !prev) break;
      prev = sync_line_i;
    end
    stuck(i);
    prev = pwm_o;
    for (dly = 1; dly < 600; dly++) begin
      @(posedge clock_i);
      #1;
      if (pwm_o && !prev) break;
      prev = pwm_o;
    end
    stuck(dly);
    for (wid = 1; wid < 600; wid++) begin
      @(posedge clock_i);
      #1;
      if (!pwm_o) break;
    end
    stuck(wid);
  endtask

  initial begin
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      rd(rst_addr[k]);
      chk(rd_val, rst_val[k]);
    end
    $display("reset value test done");
    wrchk(8'h02, 8'h40);
    wr(8'h03, 8'h01);
    measure();
    measure();
    chk(8'(wid > 50), 8'h00);
    wr(8'h03, 8'h00);
    $display("duty limit test done");
    wrchk(8'h08, 8'h12);
    wrchk(8'h0F, 8'h34);
    wrchk(8'h12, 8'h05);
    wr(8'h1F, 8'hFF);
    rd(8'h1F);
    chk(rd_val, 8'h00);
    $display("coefficient test done");
    wrchk(8'h02, 8'hC0);
    for (int k = 0; k < 3; k++) begin
      wrchk(8'h00, codes[k]);
      wr(8'h03, 8'h01);
      measure();
      measure();
      chk(8'(dly), 8'((codes[k] * 100) >> 5) + 8'h01);
      chk(8'(wid), 8'h32);
      wr(8'h00, 8'h15);
      rd(8'h00);
      chk(rd_val, codes[k]);
      wr(8'h03, 8'h00);
    end
    $display("interleave test done");
    wrchk(8'h01, 8'h02);
    wr(8'h03, 8'h01);
    measure();
    measure();
    chk(8'(wid), 8'h19);
    wr(8'h03, 8'h00);
    $display("frequency test done");
    chk(8'(n_mon), 8'h00);
    wr(8'h03, 8'h02);
    for (dly = 0; dly < 600 && n_mon < 6; dly++) @(posedge clock_i);
    stuck(dly);
    rd(8'h18);
    chk(rd_val, 8'h00);
    rd(8'h19);
    chk(rd_val, 8'h70);
    chk(share_level_o, 8'h70);
    rd(8'h1A);
    chk(rd_val, 8'h60);
    $display("monitoring test done");
    wrap_up();
  end
endmodule
